// ### lpc_pkg.sv
// Constants and types shared by the port loopback controller.
//==============================================================
package lpc_pkg;
  localparam int NCLI = 4;
  localparam int NPORT = 5;
  localparam int TRK = 4;
  localparam int DW = 8;
  localparam int AW = 4;
  localparam int RW = 16;
  localparam logic [AW-1:0] A_CTRL = 4'h0;
  localparam logic [AW-1:0] A_PROV = 4'h1;
  localparam logic [AW-1:0] A_SONET = 4'h2;
  localparam logic [AW-1:0] A_LOOP = 4'h3;
  localparam logic [AW-1:0] A_STAT = 4'h4;
  localparam int C_ADM = 0;
  localparam int C_ALM = 1;
  localparam int S_TERM = 0;
  localparam int S_FAC = 5;
  localparam int S_SUP = 10;
  localparam logic [1:0] L_NONE = 2'h0;
  localparam logic [1:0] L_FAC = 2'h1;
  localparam logic [1:0] L_TERM = 2'h2;
  localparam logic [1:0] L_BAD = 2'h3;
  localparam logic [DW-1:0] AIS_WORD = 8'hff;

  typedef struct packed {
    logic valid;
    logic [DW-1:0] data;
  } lpc_word_s;

  typedef enum logic [3:0] {
    ACT_PASS = 4'h1,
    ACT_LOOP = 4'h2,
    ACT_AIS = 4'h4,
    ACT_SQL = 4'h8
  } lpc_act_e;

  typedef struct packed {
    logic adm;
    logic alm_cfg;
    logic [NCLI-1:0] prov;
    logic [NCLI-1:0] sonet;
    logic [NPORT-1:0][1:0] loop;
    logic [NPORT-1:0] term;
    logic [NPORT-1:0] fac;
    logic [NPORT-1:0] sup;
    logic [NPORT-1:0] maint;
    logic [NPORT-1:0] alarm;
    logic [RW-1:0] rdata;
  } lpc_state_s;
endpackage

// ### lpc_lane.sv
// One lane of the loopback datapath: picks pass, loop, AIS or squelch and registers it.
`timescale 1ns/10ps
module lpc_lane (
  input wire logic clk,
  input wire logic rst_b,
  input wire lpc_pkg::lpc_act_e act,
  input wire lpc_pkg::lpc_word_s pass_w,
  input wire lpc_pkg::lpc_word_s loop_w,
  output lpc_pkg::lpc_word_s q
);
  typedef struct packed {
    lpc_pkg::lpc_word_s q;
  } lpc_lane_s;

  lpc_lane_s st;
  lpc_lane_s next_st;

  //============================================================
  // Lane select
  always_comb
  begin
    next_st = st;
    case (act)
      lpc_pkg::ACT_PASS: next_st.q = pass_w;
      lpc_pkg::ACT_LOOP: next_st.q = loop_w;
      lpc_pkg::ACT_AIS:
      begin
        next_st.q.valid = 1'b1;
        next_st.q.data = lpc_pkg::AIS_WORD;
      end
      lpc_pkg::ACT_SQL: next_st.q = '0;
      default: next_st.q = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign q = st.q;
endmodule

// ### lpc_top.sv
// Port loopback controller: registers, lane steering, conditions and alarm gating.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/10ps
module lpc_top (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [lpc_pkg::AW-1:0] REG_ADDR,
  input wire logic [lpc_pkg::RW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [lpc_pkg::RW-1:0] REG_RDATA,
  input wire lpc_pkg::lpc_word_s [lpc_pkg::NCLI-1:0] CLI_RX,
  output lpc_pkg::lpc_word_s [lpc_pkg::NCLI-1:0] CLI_TX,
  input wire lpc_pkg::lpc_word_s [lpc_pkg::NCLI-1:0] TRK_RX,
  output lpc_pkg::lpc_word_s [lpc_pkg::NCLI-1:0] TRK_TX,
  input wire logic [lpc_pkg::NPORT-1:0] ALARM_IN,
  output logic [lpc_pkg::NPORT-1:0] ALARM_OUT,
  output logic [lpc_pkg::NPORT-1:0] TERM_COND,
  output logic [lpc_pkg::NPORT-1:0] FAC_COND,
  output logic [lpc_pkg::NPORT-1:0] SUPPRESS,
  output logic [lpc_pkg::NPORT-1:0] MAINT_STATE
);
  lpc_pkg::lpc_state_s st;
  lpc_pkg::lpc_state_s next_st;

  //============================================================
  // Register file and per-port state
  always_comb
  begin
    logic [1:0] code;
    logic [lpc_pkg::NPORT-1:0] allow;
    code = lpc_pkg::L_NONE;
    // The trunk needs no pluggable module, so its permission bit is tied high.
    allow = {1'b1, st.prov};
    next_st = st;
    next_st.rdata = '0;
    if (REG_WR)
    begin
      case (REG_ADDR)
        lpc_pkg::A_CTRL:
        begin
          next_st.adm = REG_WDATA[lpc_pkg::C_ADM];
          next_st.alm_cfg = REG_WDATA[lpc_pkg::C_ALM];
        end
        lpc_pkg::A_PROV: next_st.prov = REG_WDATA[lpc_pkg::NCLI-1:0];
        lpc_pkg::A_SONET: next_st.sonet = REG_WDATA[lpc_pkg::NCLI-1:0];
        lpc_pkg::A_LOOP:
        begin
          for (int p = 0; p < lpc_pkg::NPORT; p++)
          begin
            code = REG_WDATA[2*p +: 2];
            // An unknown code is dropped so a port never holds two selections.
            if (code != lpc_pkg::L_BAD)
            begin
              if (allow[p])
                next_st.loop[p] = code;
            end
          end
        end
        default: ;
      endcase
    end
    // Pulling a module out of provisioning tears its loop down with it.
    for (int p = 0; p < lpc_pkg::NCLI; p++)
    begin
      if (!next_st.prov[p])
        next_st.loop[p] = lpc_pkg::L_NONE;
    end
    for (int p = 0; p < lpc_pkg::NPORT; p++)
    begin
      next_st.term[p] = next_st.loop[p] == lpc_pkg::L_TERM;
      next_st.fac[p] = next_st.loop[p] == lpc_pkg::L_FAC;
      // Only the looped port itself enters loop maintenance.
      next_st.maint[p] = next_st.loop[p] != lpc_pkg::L_NONE;
      next_st.sup[p] = next_st.maint[p] && !next_st.alm_cfg;
      next_st.alarm[p] = ALARM_IN[p] && !next_st.sup[p];
    end
    if (REG_RD)
    begin
      case (REG_ADDR)
        lpc_pkg::A_CTRL:
        begin
          next_st.rdata[lpc_pkg::C_ADM] = st.adm;
          next_st.rdata[lpc_pkg::C_ALM] = st.alm_cfg;
        end
        lpc_pkg::A_PROV: next_st.rdata[lpc_pkg::NCLI-1:0] = st.prov;
        lpc_pkg::A_SONET: next_st.rdata[lpc_pkg::NCLI-1:0] = st.sonet;
        lpc_pkg::A_LOOP: next_st.rdata[2*lpc_pkg::NPORT-1:0] = st.loop;
        lpc_pkg::A_STAT:
        begin
          next_st.rdata[lpc_pkg::S_TERM +: lpc_pkg::NPORT] = st.term;
          next_st.rdata[lpc_pkg::S_FAC +: lpc_pkg::NPORT] = st.fac;
          next_st.rdata[lpc_pkg::S_SUP +: lpc_pkg::NPORT] = st.sup;
        end
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      st <= '0;
    else
      st <= next_st;
  end

  assign REG_RDATA = st.rdata;
  assign TERM_COND = st.term;
  assign FAC_COND = st.fac;
  assign SUPPRESS = st.sup;
  assign MAINT_STATE = st.maint;
  assign ALARM_OUT = st.alarm;

  //============================================================
  // Lane steering
  // Client lane i rides trunk lane i by fixed mapping, so no cross-connect exists.
  for (genvar i = 0; i < lpc_pkg::NCLI; i++)
  begin : g_lane
    lpc_pkg::lpc_act_e cli_act;
    lpc_pkg::lpc_act_e trk_act;
    lpc_pkg::lpc_act_e adm_kill;

    always_comb
    begin
      adm_kill = st.sonet[i] ? lpc_pkg::ACT_AIS : lpc_pkg::ACT_SQL;
      if (st.loop[i] == lpc_pkg::L_FAC)
        cli_act = lpc_pkg::ACT_LOOP;
      else if (st.loop[i] == lpc_pkg::L_TERM)
        cli_act = st.adm ? adm_kill : lpc_pkg::ACT_PASS;
      else if (st.loop[lpc_pkg::TRK] == lpc_pkg::L_TERM)
        cli_act = lpc_pkg::ACT_LOOP;
      else if (st.loop[lpc_pkg::TRK] == lpc_pkg::L_FAC)
        cli_act = st.adm ? adm_kill : lpc_pkg::ACT_AIS;
      else
        cli_act = lpc_pkg::ACT_PASS;
    end

    always_comb
    begin
      if (st.loop[lpc_pkg::TRK] == lpc_pkg::L_FAC)
        trk_act = lpc_pkg::ACT_LOOP;
      else if (st.loop[lpc_pkg::TRK] == lpc_pkg::L_TERM)
        trk_act = lpc_pkg::ACT_PASS;
      else if (st.loop[i] == lpc_pkg::L_TERM)
        trk_act = lpc_pkg::ACT_LOOP;
      else if (st.loop[i] == lpc_pkg::L_FAC)
        trk_act = lpc_pkg::ACT_AIS;
      else
        trk_act = lpc_pkg::ACT_PASS;
    end

    // Loop sources are taken on the card side of each line unit, never through it.
    lpc_lane u_cli (
      .clk(CLK),
      .rst_b(RST_B),
      .act(cli_act),
      .pass_w(TRK_RX[i]),
      .loop_w(CLI_RX[i]),
      .q(CLI_TX[i])
    );

    lpc_lane u_trk (
      .clk(CLK),
      .rst_b(RST_B),
      .act(trk_act),
      .pass_w(CLI_RX[i]),
      .loop_w(TRK_RX[i]),
      .q(TRK_TX[i])
    );

    // Each lane answers only to its own partner lane, whatever the other lanes do.
    a_lane_idle: assert property (@(posedge CLK) disable iff (!RST_B)
      RST_B && st.loop[i] == lpc_pkg::L_NONE && st.loop[lpc_pkg::TRK] == lpc_pkg::L_NONE |=>
      CLI_TX[i] == $past(TRK_RX[i]) && TRK_TX[i] == $past(CLI_RX[i]))
      else $error("idle lane not crossed to its own partner");
    a_lane_trk_term: assert property (@(posedge CLK) disable iff (!RST_B)
      st.loop[lpc_pkg::TRK] == lpc_pkg::L_TERM && st.loop[i] == lpc_pkg::L_NONE |=>
      CLI_TX[i] == $past(CLI_RX[i]))
      else $error("trunk terminal loop missed a client lane");
  end

  //============================================================
  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  sequence s_cli_term0;
    st.loop[0] == lpc_pkg::L_TERM && st.loop[lpc_pkg::TRK] == lpc_pkg::L_NONE && !st.adm;
  endsequence

  sequence s_trk_term0;
    st.loop[lpc_pkg::TRK] == lpc_pkg::L_TERM && st.loop[0] == lpc_pkg::L_NONE;
  endsequence

  sequence s_wr_term0;
    REG_WR && REG_ADDR == lpc_pkg::A_LOOP && REG_WDATA[1:0] == lpc_pkg::L_TERM && st.prov[0];
  endsequence

  a_term_cli_return: assert property (s_cli_term0 |=> TRK_TX[0] == $past(TRK_RX[0]))
    else $error("client terminal loop did not return trunk traffic");
  a_term_cli_bridge: assert property (s_cli_term0 |=> CLI_TX[0] == $past(TRK_RX[0]))
    else $error("client terminal loop was not bridged downstream");
  a_term_trk_both: assert property (s_trk_term0 |=>
    CLI_TX[0] == $past(CLI_RX[0]) && TRK_TX[0] == $past(CLI_RX[0]))
    else $error("trunk terminal loop wrong return or forward");
  a_fac_ais_down: assert property (st.loop[0] == lpc_pkg::L_FAC &&
    st.loop[lpc_pkg::TRK] == lpc_pkg::L_NONE |=>
    TRK_TX[0].valid && TRK_TX[0].data == lpc_pkg::AIS_WORD)
    else $error("terminated facility loop sent no AIS downstream");
  a_adm_cli_kill: assert property (st.adm && st.loop[0] == lpc_pkg::L_TERM |=>
    CLI_TX[0].valid == $past(st.sonet[0]) &&
    CLI_TX[0].data == ($past(st.sonet[0]) ? lpc_pkg::AIS_WORD : 8'h00))
    else $error("add-drop client terminal loop not AIS or squelch");
  a_adm_trk_fac: assert property (st.adm && st.loop[lpc_pkg::TRK] == lpc_pkg::L_FAC &&
    st.loop[0] == lpc_pkg::L_NONE |=> CLI_TX[0].valid == $past(st.sonet[0]))
    else $error("add-drop trunk facility loop client output wrong");
  a_cond_report: assert property (s_wr_term0 |=> TERM_COND[0] && MAINT_STATE[0])
    else $error("terminal loop condition not reported");
  a_alarm_gate: assert property (SUPPRESS[0] |-> !ALARM_OUT[0] && !st.alm_cfg)
    else $error("alarm passed while suppressed");
  a_unprov_none: assert property (!st.prov[0] |-> st.loop[0] == lpc_pkg::L_NONE)
    else $error("loop held on unprovisioned client");

  sequence s_trk_fac0;
    !st.adm && st.loop[lpc_pkg::TRK] == lpc_pkg::L_FAC && st.loop[0] == lpc_pkg::L_NONE;
  endsequence

  sequence s_adm_trk_term0;
    st.adm && st.loop[lpc_pkg::TRK] == lpc_pkg::L_TERM && st.loop[0] == lpc_pkg::L_NONE;
  endsequence

  sequence s_wr_fac0;
    REG_WR && REG_ADDR == lpc_pkg::A_LOOP && REG_WDATA[1:0] == lpc_pkg::L_FAC && st.prov[0];
  endsequence

  a_cli_fac_loop: assert property (st.loop[0] == lpc_pkg::L_FAC |=>
    CLI_TX[0] == $past(CLI_RX[0]))
    else $error("client facility loop did not return client traffic");
  a_trk_fac_loop: assert property (st.loop[lpc_pkg::TRK] == lpc_pkg::L_FAC |=>
    TRK_TX[0] == $past(TRK_RX[0]))
    else $error("trunk facility loop did not return trunk traffic");
  a_trk_fac_ais: assert property (s_trk_fac0 |=>
    CLI_TX[0].valid && CLI_TX[0].data == lpc_pkg::AIS_WORD)
    else $error("terminated trunk facility loop sent no AIS to client");
  a_adm_trk_drop: assert property (s_adm_trk_term0 |=>
    TRK_TX[0] == $past(CLI_RX[0]))
    else $error("add-drop trunk terminal loop stopped forwarding");
  a_fac_cond: assert property (s_wr_fac0 |=>
    FAC_COND[0] && !TERM_COND[0] && MAINT_STATE[0])
    else $error("facility loop condition not reported");
  a_maint_own: assert property (REG_WR && REG_ADDR == lpc_pkg::A_LOOP &&
    REG_WDATA[9:0] == 10'h008 && st.prov[1] |=> MAINT_STATE == 5'h02)
    else $error("maintenance state spread beyond the looped client");
  a_trk_maint: assert property (REG_WR && REG_ADDR == lpc_pkg::A_LOOP &&
    REG_WDATA[9:8] == lpc_pkg::L_TERM |=> MAINT_STATE[lpc_pkg::TRK] && TERM_COND[lpc_pkg::TRK])
    else $error("trunk terminal loop not in maintenance");
  a_bad_keep: assert property (REG_WR && REG_ADDR == lpc_pkg::A_LOOP &&
    REG_WDATA[3:2] == lpc_pkg::L_BAD && st.prov[1] |=> st.loop[1] == $past(st.loop[1]))
    else $error("unknown loop code changed a port selection");
  a_unprov_drop: assert property (REG_WR && REG_ADDR == lpc_pkg::A_PROV &&
    !REG_WDATA[0] |=> st.loop[0] == lpc_pkg::L_NONE && !TERM_COND[0] && !FAC_COND[0])
    else $error("client loop survived losing its module");
  a_alarm_all: assert property ((SUPPRESS & ALARM_OUT) == 5'h00)
    else $error("alarm passed on a suppressed port");
  // The first cycle after reset still shows the cleared alarm register, so it is skipped.
  a_alarm_pass: assert property (!SUPPRESS[0] && $past(RST_B) |->
    ALARM_OUT[0] == $past(ALARM_IN[0]))
    else $error("alarm lost while not suppressed");
endmodule

// ### lpc_far.sv
// Far-side model: test set and downstream gear feeding the client and trunk lanes.
`timescale 1ns/10ps
module lpc_far (
  input wire logic clk,
  input wire logic rst_b,
  output lpc_pkg::lpc_word_s [lpc_pkg::NCLI-1:0] cli_rx,
  output lpc_pkg::lpc_word_s [lpc_pkg::NCLI-1:0] trk_rx
);
  //==============================================================
  // Traffic pattern
  // Words change every cycle, so a stale or misrouted word is seen at once.
  // Low bits mark the source, so no word ever looks like AIS or a squelch.
  logic [3:0] cnt;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt <= 4'h0;
    else
      cnt <= cnt + 4'h1;
  end
  always_comb
  begin
    for (int i = 0; i < lpc_pkg::NCLI; i++)
    begin
      cli_rx[i] = {~(cnt[2] & cnt[1]), cnt, 2'(i), 2'h1};
      trk_rx[i] = {~(cnt[2] & cnt[0]), cnt, 2'(i), 2'h2};
    end
  end
endmodule

// ### testbench.sv
// Self-checking testbench for the port loopback controller.
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [lpc_pkg::AW-1:0] reg_addr = '0;
  logic [lpc_pkg::RW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [lpc_pkg::RW-1:0] reg_rdata;
  lpc_pkg::lpc_word_s [lpc_pkg::NCLI-1:0] cli_rx, cli_tx, trk_rx, trk_tx;
  logic [4:0] alarm_in = 5'h1f;
  logic [4:0] alarm_out, term_cond, fac_cond, suppress, maint_state;
  int err_count = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  lpc_far far_u (.clk(clk), .rst_b(rst_b), .cli_rx(cli_rx), .trk_rx(trk_rx));
  lpc_top dut_u (.CLK(clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CLI_RX(cli_rx),
    .CLI_TX(cli_tx), .TRK_RX(trk_rx), .TRK_TX(trk_tx), .ALARM_IN(alarm_in),
    .ALARM_OUT(alarm_out), .TERM_COND(term_cond), .FAC_COND(fac_cond),
    .SUPPRESS(suppress), .MAINT_STATE(maint_state));
  //==============================================================
  // Shared tasks
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, exp);
  endtask
  // Source codes: 0 client input, 1 trunk input, 2 AIS, 3 squelch.
  function automatic lpc_pkg::lpc_word_s pick(input logic [1:0] s,
    input lpc_pkg::lpc_word_s c, input lpc_pkg::lpc_word_s t);
    case (s)
      2'h0: pick = c;
      2'h1: pick = t;
      2'h2: pick = {1'b1, lpc_pkg::AIS_WORD};
      default: pick = '0;
    endcase
  endfunction
  task automatic lanes(input logic [7:0] cs, input logic [7:0] ts);
    lpc_pkg::lpc_word_s [lpc_pkg::NCLI-1:0] c, t;
    @(posedge clk);
    #1;
    c = cli_rx;
    t = trk_rx;
    @(posedge clk);
    #1;
    for (int i = 0; i < lpc_pkg::NCLI; i++)
    begin
      cmp(16'(cli_tx[i]), 16'(pick(cs[2*i+:2], c[i], t[i])));
      cmp(16'(trk_tx[i]), 16'(pick(ts[2*i+:2], c[i], t[i])));
    end
  endtask
  task automatic conds(input logic [4:0] tc, fc, mt, ao, sp);
    @(posedge clk);
    #1;
    cmp(16'(term_cond), 16'(tc));
    cmp(16'(fac_cond), 16'(fc));
    cmp(16'(maint_state), 16'(mt));
    cmp(16'(alarm_out), 16'(ao));
    cmp(16'(suppress), 16'(sp));
  endtask
  //==============================================================
  // Scenarios
  task automatic t_idle;
    lanes(8'h55, 8'h00);
    rd(lpc_pkg::A_STAT, 16'h0000);
    rd(4'hf, 16'h0000);
    @(posedge clk);
    alarm_in <= 5'h0a;
    conds(5'h00, 5'h00, 5'h00, 5'h0a, 5'h00);
    @(posedge clk);
    alarm_in <= 5'h1f;
    wr(lpc_pkg::A_LOOP, 16'h0002);
    conds(5'h00, 5'h00, 5'h00, 5'h1f, 5'h00);
  endtask
  task automatic t_cli_term;
    wr(lpc_pkg::A_PROV, 16'h000f);
    rd(lpc_pkg::A_PROV, 16'h000f);
    // The trunk field stays at none, so the trunk remains in service.
    wr(lpc_pkg::A_LOOP, 16'h0008);
    conds(5'h02, 5'h00, 5'h02, 5'h1d, 5'h02);
    lanes(8'h55, 8'h04);
    rd(lpc_pkg::A_STAT, 16'h0802);
    wr(lpc_pkg::A_LOOP, 16'h000e);
    rd(lpc_pkg::A_LOOP, 16'h000a);
    lanes(8'h55, 8'h05);
    wr(lpc_pkg::A_CTRL, 16'h0002);
    rd(lpc_pkg::A_CTRL, 16'h0002);
    conds(5'h03, 5'h00, 5'h03, 5'h1f, 5'h00);
    wr(lpc_pkg::A_CTRL, 16'h0000);
  endtask
  task automatic t_trk_term;
    wr(lpc_pkg::A_LOOP, 16'h0200);
    conds(5'h10, 5'h00, 5'h10, 5'h0f, 5'h10);
    lanes(8'h00, 8'h00);
  endtask
  task automatic t_fac;
    // Client facility loops with the trunk field at none keep the trunk unlocked.
    wr(lpc_pkg::A_LOOP, 16'h0011);
    conds(5'h00, 5'h05, 5'h05, 5'h1a, 5'h05);
    lanes(8'h44, 8'h22);
    wr(lpc_pkg::A_LOOP, 16'h0100);
    lanes(8'haa, 8'h55);
  endtask
  task automatic t_adm;
    wr(lpc_pkg::A_CTRL, 16'h0001);
    wr(lpc_pkg::A_SONET, 16'h0005);
    rd(lpc_pkg::A_SONET, 16'h0005);
    wr(lpc_pkg::A_LOOP, 16'h00aa);
    lanes(8'hee, 8'h55);
    wr(lpc_pkg::A_LOOP, 16'h0100);
    lanes(8'hee, 8'h55);
    wr(lpc_pkg::A_LOOP, 16'h0200);
    lanes(8'h00, 8'h00);
    wr(lpc_pkg::A_LOOP, 16'h0002);
    wr(lpc_pkg::A_PROV, 16'h0000);
    rd(lpc_pkg::A_LOOP, 16'h0000);
    lanes(8'h55, 8'h00);
  endtask
  //==============================================================
  // Run control
  task automatic finish_test;
    $display("mismatches %0d, checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // The whole sequence needs under a hundred cycles; this 5000-cycle limit leaves ample slack.
  initial
  begin
    #(25 * 5000);
    err_count++;
    finish_test();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_idle();
    t_cli_term();
    t_trk_term();
    t_fac();
    t_adm();
    finish_test();
  end
endmodule
